//--- charger_battery_model.sv
/*
  Far-side model: a current-limited DC charger and a Li-Ion battery, seen
  through the measurement converter. Assumes the bench commands the levels
  and that the converter refreshes its codes once per clock.
*/
`timescale 1ns/100ps

module charger_battery_model
(
  // clock
  input wire logic clock,
  // commanded conditions
  input wire logic [15:0] wantChg,
  input wire logic [15:0] wantBat,
  input wire logic signed [15:0] wantTemp,
  // measured codes towards the controller
  output logic [15:0] chargerMv = 16'h0000,
  output logic [15:0] batteryMv = 16'h0000,
  output logic signed [15:0] tempDeci = 16'sh0000
);
  // ---------------------------------------------------------------------
  // converter refresh
  // ---------------------------------------------------------------------
  // codes change just after the edge; a detached charger reads zero volts
  always @(posedge clock)
  begin
    chargerMv <= wantChg;
    batteryMv <= wantBat;
    tempDeci <= wantTemp;
  end
endmodule : charger_battery_model

//--- charger_defines.svh
/*
  Constants of the battery charge controller: measurement thresholds,
  pulse timing and the digitized scale. Assumes millivolt and tenth-degree
  measurement codes from an external converter.
*/
`ifndef CHARGER_DEFINES_SVH
`define CHARGER_DEFINES_SVH

// ----------------------------------------------------------------------------
// measurement scale
// ----------------------------------------------------------------------------
`define MEAS_W 16
// voltages in mV, temperature in 0.1 degC, signed
`define CHG_MIN_MV 16'h15E0
`define CHG_MAX_MV 16'h3A98
`define BAT_DEEP_MV 16'h0C1C
`define BAT_FULL_MV 16'h1068
`define BAT_OVER_MV 16'h1176
`define TEMP_LO_OFF 16'sh0000
`define TEMP_LO_ON 16'sh0032
`define TEMP_HI_OFF 16'sh0190
`define TEMP_HI_ON 16'sh015E

// ----------------------------------------------------------------------------
// pulse timing
// ----------------------------------------------------------------------------
`define CLOCK_HZ 100000000
`define PULSE_HZ 100
`define PERIOD_CYCLES (`CLOCK_HZ / `PULSE_HZ)
`define PER_W 20
// on-time in per-mille of a period
`define PRE_ON_PERMILLE 125
`define FAST_ON_PERMILLE 990
// top charge: consecutive periods at full voltage before trickle
`define TOP_DONE_PERIODS 8'h64
// trickle on-time, per-mille
`define TRICKLE_ON_PERMILLE 50

`endif

//--- charger_pkg.sv
/*
  Types of the battery charge controller. Assumes charger_defines.svh.
*/
package charger_pkg;
  typedef enum logic [2:0] {IDLE, PRE, FAST, TOP, TRICKLE} phase_t;
endpackage : charger_pkg

//--- liion_charge_controller.sv
/*
  Li-Ion charge controller: charger detection, power-on request, phase
  sequencing, pulsed charge switch, temperature and over-voltage gating.
  Assumes measurement codes arrive asynchronously from a converter.
*/
// What this block does
// R1 - charger valid only while sense voltage lies within 5.6 V to 15 V
// R2 - valid charger while switched off requests power-on in charging mode
// R3 - phases run pre, fast, top, trickle in fixed order
// R4 - deep-discharged battery with valid charger starts pre-charge, even unpowered
// R5 - pre-charge pulses switch at 100 Hz, on one eighth of period
// R6 - pre-charge is hardware-only until battery reaches 3.1 V, then fast
// R7 - fast charge pulses at 100 Hz with 99 percent on-time
// R8 - fast charge checks charger presence during the off interval
// R9 - at 4.2 V switch to constant-voltage top charge until full
// R10 - after top charge, trickle while charger stays connected
// R11 - inhibit below 0 C, re-enable only above 5 C
// R12 - inhibit above 40 C, re-enable only below 35 C
// R13 - stop charging when battery exceeds 4.47 V over-voltage
// R14 - charger removed disables charging and opens the switch; top charge holds the switch closed, so presence is not refreshed there
// R15 - all comparisons made on digitized measurements against constant thresholds
// R16 - pulse period from clock divider, on-time compare chosen by phase
`timescale 1ns/100ps
`include "charger_defines.svh"

module liion_charge_controller
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // digitized measurements
  input wire logic [`MEAS_W-1:0] chargerMv,
  input wire logic [`MEAS_W-1:0] batteryMv,
  input wire logic signed [`MEAS_W-1:0] tempDeci,
  // device power status
  input wire logic devicePowered,
  // outputs
  output logic chargeSwitch,
  output logic powerOnRequest,
  output logic chargingMode,
  output logic [2:0] phase,
  output logic tempInhibit,
  output logic overVoltage
);
  // --------------------------------------------------------------------------
  // constants
  // --------------------------------------------------------------------------
  localparam logic [`PER_W-1:0] PRE_ON = `PER_W'(`PERIOD_CYCLES * `PRE_ON_PERMILLE / 1000);
  localparam logic [`PER_W-1:0] FAST_ON = `PER_W'(`PERIOD_CYCLES * `FAST_ON_PERMILLE / 1000);
  localparam logic [`PER_W-1:0] TRICKLE_ON = `PER_W'(`PERIOD_CYCLES * `TRICKLE_ON_PERMILLE / 1000);

  typedef struct packed
  {
    logic [`MEAS_W-1:0] chg1;
    logic [`MEAS_W-1:0] chg2;
    logic [`MEAS_W-1:0] chg3;
    logic [`MEAS_W-1:0] chgTaken;
    logic [`MEAS_W-1:0] bat1;
    logic [`MEAS_W-1:0] bat2;
    logic [`MEAS_W-1:0] bat3;
    logic [`MEAS_W-1:0] batTaken;
    logic [`MEAS_W-1:0] tmp1;
    logic [`MEAS_W-1:0] tmp2;
    logic [`MEAS_W-1:0] tmp3;
    logic [`MEAS_W-1:0] tmpTaken;
    logic pwr1;
    logic pwr2;
    charger_pkg::phase_t ph;
    logic cold;
    logic hot;
    logic ovp;
    logic present;
    logic pwrReq;
    logic [7:0] topCount;
  } cstate_t;

  cstate_t st;
  cstate_t next_st;
  logic chargerValid;
  logic allowed;
  logic run;
  logic [`PER_W-1:0] onCycles;
  logic pulseOn;
  logic offWindow;
  logic periodEnd;

  // --------------------------------------------------------------------------
  // decoding
  // --------------------------------------------------------------------------
  // inclusive window on the synchronised sense value
  function automatic logic in_window(input logic [`MEAS_W-1:0] v);
    in_window = (v >= `CHG_MIN_MV) && (v <= `CHG_MAX_MV); // R1 R15
  endfunction : in_window

  assign chargerValid = in_window(st.chgTaken);
  assign allowed = st.present && !st.cold && !st.hot && !st.ovp;

  // phase selects the compare value
  always_comb
  begin
    unique case (st.ph)
      charger_pkg::PRE: onCycles = PRE_ON; // R5
      charger_pkg::FAST: onCycles = FAST_ON; // R7
      charger_pkg::TRICKLE: onCycles = TRICKLE_ON; // R10 R16
      default: onCycles = `PER_W'(`PERIOD_CYCLES); // top: held on, voltage-limited
    endcase
  end

  assign run = allowed && (st.ph != charger_pkg::IDLE);

  pulse_gen u_pulse
  (
    .clock(clock),
    .rst(rst),
    .run(run),
    .onCycles(onCycles),
    .pulseOn(pulseOn),
    .offWindow(offWindow),
    .periodEnd(periodEnd)
  );

  // --------------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    // two flops on each asynchronous measurement, then one more sample
    next_st.chg1 = chargerMv;
    next_st.chg2 = st.chg1;
    next_st.chg3 = st.chg2;
    next_st.bat1 = batteryMv;
    next_st.bat2 = st.bat1;
    next_st.bat3 = st.bat2;
    next_st.tmp1 = tempDeci;
    next_st.tmp2 = st.tmp1;
    next_st.tmp3 = st.tmp2;
    next_st.pwr1 = devicePowered;
    next_st.pwr2 = st.pwr1;

    // a word is taken only when two synced samples agree, so a code caught
    // mid-change never meets a threshold; a code that never settles is never taken
    if (st.chg2 == st.chg3)
      next_st.chgTaken = st.chg2;
    if (st.bat2 == st.bat3)
      next_st.batTaken = st.bat2;
    if (st.tmp2 == st.tmp3)
      next_st.tmpTaken = st.tmp2;

    // presence: refreshed when switch is open, since closed switch masks sense
    if (st.ph == charger_pkg::IDLE || !pulseOn)
      next_st.present = chargerValid; // R8 R14

    // temperature hysteresis
    if ($signed(st.tmpTaken) < `TEMP_LO_OFF)
      next_st.cold = 1'b1; // R11
    else if ($signed(st.tmpTaken) > `TEMP_LO_ON)
      next_st.cold = 1'b0; // R11
    if ($signed(st.tmpTaken) > `TEMP_HI_OFF)
      next_st.hot = 1'b1; // R12
    else if ($signed(st.tmpTaken) < `TEMP_HI_ON)
      next_st.hot = 1'b0; // R12

    // over-voltage latches until the charger goes away; a new excess wins over the clear
    if (st.batTaken > `BAT_OVER_MV)
      next_st.ovp = 1'b1; // R13
    else if (!st.present)
      next_st.ovp = 1'b0;

    // power-on request while a charger is present and device off
    next_st.pwrReq = st.present && !st.pwr2; // R2

    unique case (st.ph)
      charger_pkg::IDLE:
        if (st.present)
          next_st.ph = (st.batTaken < `BAT_DEEP_MV) ? charger_pkg::PRE : charger_pkg::FAST; // R3 R4
      charger_pkg::PRE:
        if (st.batTaken >= `BAT_DEEP_MV)
          next_st.ph = charger_pkg::FAST; // R6
      charger_pkg::FAST:
        if (st.batTaken >= `BAT_FULL_MV)
        begin
          next_st.ph = charger_pkg::TOP; // R9
          next_st.topCount = 8'h00;
        end
      charger_pkg::TOP:
        // full when voltage stays at maximum for a run of periods
        if (periodEnd)
        begin
          if (st.batTaken < `BAT_FULL_MV)
            next_st.topCount = 8'h00;
          else if (st.topCount == `TOP_DONE_PERIODS - 8'h01)
            next_st.ph = charger_pkg::TRICKLE; // R10
          else
            next_st.topCount = st.topCount + 8'h01;
        end
      charger_pkg::TRICKLE:
        next_st.ph = charger_pkg::TRICKLE; // R10
      default:
        next_st.ph = charger_pkg::IDLE;
    endcase

    // charger removal ends the sequence from any phase
    if (!st.present)
      next_st.ph = charger_pkg::IDLE; // R14
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      st <= '0;
      st.ph <= charger_pkg::IDLE;
    end
    else
      st <= next_st;
  end

  // --------------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------------
  assign chargeSwitch = pulseOn; // R14
  assign powerOnRequest = st.pwrReq;
  assign chargingMode = st.ph != charger_pkg::IDLE;
  assign phase = st.ph;
  assign tempInhibit = st.cold || st.hot;
  assign overVoltage = st.ovp;

  // --------------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------------
  a_valid_window: assert property (@(posedge clock) disable iff (rst) // R1
    (st.ph == charger_pkg::IDLE && !in_window(st.chgTaken)) |=> !st.present)
    else $error("out-of-window charger taken as present");
  a_power_request: assert property (@(posedge clock) disable iff (rst) // R2
    (st.present && !st.pwr2) |=> powerOnRequest)
    else $error("no power-on request for valid charger");
  a_request_drop: assert property (@(posedge clock) disable iff (rst) // R2
    !st.present |=> !powerOnRequest)
    else $error("power-on request without a charger");
  a_phase_order: assert property (@(posedge clock) disable iff (rst) // R3
    (st.ph == charger_pkg::PRE) |=> (phase == charger_pkg::PRE || phase == charger_pkg::FAST
      || phase == charger_pkg::IDLE))
    else $error("pre-charge left out of order");
  a_deep_start: assert property (@(posedge clock) disable iff (rst) // R4
    (st.ph == charger_pkg::IDLE && st.present && st.batTaken < `BAT_DEEP_MV) |=> phase == charger_pkg::PRE)
    else $error("deep battery did not start pre-charge");
  sequence pre_off_s;
    (st.ph == charger_pkg::PRE && run && !pulseOn);
  endsequence
  // a gate drops run one edge after its cause, and the switch flop follows an edge later
  sequence gate_s;
    !run ##1 !chargeSwitch;
  endsequence
  a_pre_duty: assert property (@(posedge clock) disable iff (rst) // R5
    (st.ph == charger_pkg::PRE && run && pulseOn) |-> u_pulse.st.count < PRE_ON)
    else $error("pre-charge pulse too long");
  a_pre_exit: assert property (@(posedge clock) disable iff (rst) // R6
    (st.ph == charger_pkg::PRE && st.present && st.batTaken >= `BAT_DEEP_MV) |=> phase == charger_pkg::FAST)
    else $error("pre-charge did not advance");
  // the first fast cycle still shows the pre-charge compare, so it is left out
  a_fast_duty: assert property (@(posedge clock) disable iff (rst) // R7
    (st.ph == charger_pkg::FAST && $past(st.ph) == charger_pkg::FAST && run && $past(run) && !pulseOn)
      |-> u_pulse.st.count >= FAST_ON)
    else $error("fast-charge switch opened early");
  a_off_sample: assert property (@(posedge clock) disable iff (rst) // R8
    (st.ph == charger_pkg::FAST && !pulseOn && !chargerValid) |=> !st.present)
    else $error("removal missed in off interval");
  a_off_window: assert property (@(posedge clock) disable iff (rst) // R8
    (st.ph == charger_pkg::FAST && offWindow && !chargerValid) |=> !st.present)
    else $error("off window did not refresh presence");
  a_top_entry: assert property (@(posedge clock) disable iff (rst) // R9
    (st.ph == charger_pkg::FAST && st.present && st.batTaken >= `BAT_FULL_MV) |=> phase == charger_pkg::TOP)
    else $error("top charge not entered");
  a_top_hold: assert property (@(posedge clock) disable iff (rst) // R9
    (st.ph == charger_pkg::TOP && st.present && !periodEnd) |=> phase == charger_pkg::TOP)
    else $error("top charge left between periods");
  a_top_switch: assert property (@(posedge clock) disable iff (rst) // R9
    (st.ph == charger_pkg::TOP && $past(st.ph) == charger_pkg::TOP && run && $past(run)) |-> chargeSwitch)
    else $error("switch open during top charge");
  a_trickle_hold: assert property (@(posedge clock) disable iff (rst) // R10
    (st.ph == charger_pkg::TRICKLE && st.present) |=> phase == charger_pkg::TRICKLE)
    else $error("trickle left with charger attached");
  a_cold_gate: assert property (@(posedge clock) disable iff (rst) // R11
    ($signed(st.tmpTaken) < `TEMP_LO_OFF) |=> gate_s)
    else $error("charging while cold");
  a_hot_gate: assert property (@(posedge clock) disable iff (rst) // R12
    ($signed(st.tmpTaken) > `TEMP_HI_OFF) |=> gate_s)
    else $error("charging while hot");
  a_over_volt: assert property (@(posedge clock) disable iff (rst) // R13
    (st.batTaken > `BAT_OVER_MV) |=> gate_s)
    else $error("charging above over-voltage");
  a_ovp_hold: assert property (@(posedge clock) disable iff (rst) // R13
    (st.ovp && st.present) |=> overVoltage)
    else $error("over-voltage latch lost with charger attached");
  a_removed_off: assert property (@(posedge clock) disable iff (rst) // R14
    pre_off_s ##0 !chargerValid |=> gate_s)
    else $error("switch closed after removal");
  a_removal_idle: assert property (@(posedge clock) disable iff (rst) // R14
    !st.present |=> phase == charger_pkg::IDLE)
    else $error("sequence kept without a charger");
  a_idle_open: assert property (@(posedge clock) disable iff (rst) // R14
    (st.ph == charger_pkg::IDLE) |=> !chargeSwitch)
    else $error("switch closed while idle");
endmodule : liion_charge_controller

//--- liion_charge_controller_tb_top.sv
/*
  Self-checking bench of the charge controller: a model of the expected
  latches and switch is compared with the outputs after each step, and of
  the phase after each step with no inhibit or over-voltage expected.
  Assumes the far-side model and a 100 MHz clock; runs stay well inside
  the first pre-charge on-time, so the switch is expected closed.
*/
`timescale 1ns/100ps
`include "charger_defines.svh"

module liion_charge_controller_tb_top;
  // ---------------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------------
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic devicePowered = 1'b0;
  logic [15:0] wantChg = 16'h0000;
  logic [15:0] wantBat = 16'h0000;
  logic signed [15:0] wantTemp = 16'sh0000;
  logic [15:0] chargerMv;
  logic [15:0] batteryMv;
  logic signed [15:0] tempDeci;
  logic chargeSwitch, powerOnRequest, chargingMode, tempInhibit, overVoltage;
  logic [2:0] phase;
  logic [2:0] ePh = 3'h0;
  logic eCold = 1'b0;
  logic eHot = 1'b0;
  logic eOv = 1'b0;
  int errors = 0;
  int n_compared = 0;
  int cycles = 0;
  int seed = 68930;
  int cv[5] = '{16'h15DF, 16'h15E0, 16'h3A98, 16'h3A99, 16'h0000};

  // ---------------------------------------------------------------------
  // instances
  // ---------------------------------------------------------------------
  charger_battery_model i_far (.clock(clock), .wantChg(wantChg), .wantBat(wantBat),
    .wantTemp(wantTemp), .chargerMv(chargerMv), .batteryMv(batteryMv), .tempDeci(tempDeci));
  liion_charge_controller i_dut (.clock(clock), .rst(rst), .chargerMv(chargerMv),
    .batteryMv(batteryMv), .tempDeci(tempDeci), .devicePowered(devicePowered),
    .chargeSwitch(chargeSwitch), .powerOnRequest(powerOnRequest), .chargingMode(chargingMode),
    .phase(phase), .tempInhibit(tempInhibit), .overVoltage(overVoltage));

  // clock and hang guard; a full pulse period is far beyond this budget
  always #5 clock = ~clock;
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 16'h1388)
    begin
      errors = errors + 1;
      $display("[ERR] cycles expected %0d seen %0d", 16'h1388, cycles);
      wrap_up();
    end
  end

  // ---------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------
  function automatic int rnd(input int lo, input int span);
    rnd = lo + int'({$random(seed)} % span);
  endfunction : rnd

  task automatic chk_bit(input string name, input logic exp, input logic got);
    n_compared = n_compared + 1;
    if (got !== exp)
    begin
      errors = errors + 1;
      $display("[ERR] %s expected %b seen %b", name, exp, got);
    end
  endtask : chk_bit

  task automatic chk_phase(input logic [2:0] exp, input logic [2:0] got);
    n_compared = n_compared + 1;
    if (got !== exp)
    begin
      errors = errors + 1;
      $display("[ERR] phase expected %0d seen %0d", exp, got);
    end
  endtask : chk_phase

  // reset held four cycles; model state cleared with it
  task automatic do_reset();
    @(posedge clock);
    rst <= 1'b1;
    // detach the charger so a level left from the last step cannot restart a sequence
    wantChg <= 16'h0000;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    ePh = 3'h0;
    eCold = 1'b0;
    eHot = 1'b0;
    eOv = 1'b0;
    #1;
    chk_phase(3'h0, phase);
    chk_bit("chargeSwitch", 1'b0, chargeSwitch);
  endtask : do_reset

  // one step: new conditions, settle past sync and register, then compare
  task automatic apply(input int c, input int b, input int t, input logic pw);
    logic pres;
    logic inh;
    @(posedge clock);
    wantChg <= c[15:0];
    wantBat <= b[15:0];
    wantTemp <= t[15:0];
    devicePowered <= pw;
    repeat (10) @(posedge clock);
    #1;
    pres = (c >= `CHG_MIN_MV && c <= `CHG_MAX_MV);
    if (t < `TEMP_LO_OFF)
      eCold = 1'b1;
    else if (t > `TEMP_LO_ON)
      eCold = 1'b0;
    if (t > `TEMP_HI_OFF)
      eHot = 1'b1;
    else if (t < `TEMP_HI_ON)
      eHot = 1'b0;
    if (b > `BAT_OVER_MV)
      eOv = 1'b1;
    if (!pres)
      ePh = charger_pkg::IDLE;
    else if (ePh == charger_pkg::IDLE)
      ePh = (b < `BAT_DEEP_MV) ? charger_pkg::PRE : charger_pkg::FAST;
    else if (ePh == charger_pkg::PRE && b >= `BAT_DEEP_MV)
      ePh = charger_pkg::FAST;
    else if (ePh == charger_pkg::FAST && b >= `BAT_FULL_MV)
      ePh = charger_pkg::TOP;
    inh = eCold | eHot;
    chk_bit("powerOnRequest", pres & ~pw, powerOnRequest);
    chk_bit("chargingMode", ePh != 3'h0, chargingMode);
    chk_bit("tempInhibit", inh, tempInhibit);
    chk_bit("overVoltage", eOv, overVoltage);
    chk_bit("chargeSwitch", (ePh != 3'h0) & ~inh & ~eOv, chargeSwitch);
    if (!inh && !eOv)
      chk_phase(ePh, phase);
  endtask : apply

  task automatic wrap_up();
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : wrap_up

  // ---------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------
  initial
  begin
    cv[4] = rnd(16'h15E0, 16'h24B9);
    // detection window edges and one random inside, deep battery
    for (int i = 0; i < 5; i++)
    begin
      do_reset();
      apply(cv[i], 16'h0BB8, 16'h00FA, 1'b0);
    end
    // full walk through pre, fast and top with thresholds just missed
    do_reset();
    apply(16'h1770, 16'h0BB8, rnd(16'h003C, 16'h0118), 1'b0);
    apply(16'h1770, 16'h0C1B, rnd(16'h003C, 16'h0118), 1'b0);
    apply(16'h1770, 16'h0C1C, rnd(16'h003C, 16'h0118), 1'b0);
    apply(16'h1770, 16'h1067, rnd(16'h003C, 16'h0118), 1'b1);
    apply(16'h1770, 16'h1068, rnd(16'h003C, 16'h0118), 1'b1);
    // temperature hysteresis on both ends while fast charging
    do_reset();
    apply(16'h1770, 16'h0DAC, 16'h00FA, 1'b1);
    apply(16'h1770, 16'h0DAC, 16'shFFFF, 1'b1);
    apply(16'h1770, 16'h0DAC, 16'h0032, 1'b1);
    apply(16'h1770, 16'h0DAC, 16'h0033, 1'b1);
    apply(16'h1770, 16'h0DAC, 16'h0191, 1'b1);
    apply(16'h1770, 16'h0DAC, 16'h015E, 1'b1);
    apply(16'h1770, 16'h0DAC, 16'h015D, 1'b1);
    // over-voltage: limit itself is still fine, one more millivolt is not
    do_reset();
    apply(16'h1770, 16'h0DAC, 16'h00FA, 1'b1);
    apply(16'h1770, 16'h1176, 16'h00FA, 1'b1);
    apply(16'h1770, 16'h1177, 16'h00FA, 1'b1);
    wrap_up();
  end
endmodule : liion_charge_controller_tb_top

//--- pulse_gen.sv
/*
  Divides the clock into the switch pulse period and compares against the
  on-time. Assumes a change of on-time mid-period may stretch or cut one pulse.
*/
`timescale 1ns/100ps
`include "charger_defines.svh"

module pulse_gen
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // control
  input wire logic run,
  input wire logic [`PER_W-1:0] onCycles,
  // outputs
  output logic pulseOn,
  output logic offWindow,
  output logic periodEnd
);
  typedef struct packed
  {
    logic [`PER_W-1:0] count;
    logic on;
    logic off;
  } pstate_t;

  localparam logic [`PER_W-1:0] LAST = `PER_W'(`PERIOD_CYCLES - 1);

  pstate_t st;
  pstate_t next_st;

  // period counter and compare, on-time first in each period
  always_comb
  begin
    next_st = st;
    if (!run || st.count == LAST)
      next_st.count = '0;
    else
      next_st.count = st.count + `PER_W'(1);
    next_st.on = run && (next_st.count < onCycles); // R16
    next_st.off = run && !next_st.on;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      st <= '0;
    else
      st <= next_st;
  end

  assign pulseOn = st.on;
  assign offWindow = st.off;
  assign periodEnd = run && (st.count == LAST);

  a_period_wrap: assert property (@(posedge clock) disable iff (rst)
    (run && st.count == LAST) |=> (st.count == '0)) // R16
    else $error("period counter did not wrap");
endmodule : pulse_gen
